/* File: hw/uart_mcls_defs.svh */
`ifndef UART_MCLS_DEFS_SVH
`define UART_MCLS_DEFS_SVH

// =========================================================
// Register byte addresses
`define ADDR_FIFO_CONTROL 32'h5000_1108
`define ADDR_MODEM_CONTROL 32'h5000_1110
`define ADDR_LINE_STATUS 32'h5000_1114
`define ADDR_INTERRUPT_ENABLE 32'h5000_1140
`define ADDR_IRQ_STATUS 32'h5000_1144
`define ADDR_IRQ_MASK 32'h5000_1148

// =========================================================
// Modem control fields
`define MC_DTR 0
`define MC_RTS 1
`define MC_OUT1 2
`define MC_OUT2 3
`define MC_LOOP 4
`define MC_AFCE 5
`define MC_SIRE 6
`define MC_RST 7'h00

// =========================================================
// Line status fields
`define LS_BI 4
`define LS_THRE 5
`define LS_TEMT 6
`define LS_RFE 7
`define THRE_RST 1'b1
`define TEMT_RST 1'b1

// =========================================================
// Fifo control and interrupt enable fields
`define FC_EN 0
`define FC_TXT_LO 4
`define FC_RXT_LO 6
`define FC_RST 8'h00
`define IE_PTIME 7

// =========================================================
// Interrupt status and mask fields
`define IRQ_THRE 0
`define IRQ_BI 1
`define IRQ_RFE 2
`define IRQ_RST 3'h0

// =========================================================
// Timing
`define OVERSAMPLE 16
`define START_STOP_BITS 2

`endif

/* File: hw/uart_mcls_pkg.sv */
package uart_mcls_pkg;
   typedef enum logic {BRK_HUNT, BRK_HOLD} brk_state_t;
   typedef struct packed {
      logic bi;
      logic fe;
      logic pe;
   } rx_stat_t;
endpackage

/* File: hw/break_detector.sv */
`timescale 1ns/1ps
`include "uart_mcls_defs.svh"

module break_detector import uart_mcls_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // Line
   input wire logic baud_tick,
   input wire logic ir_mode,
   input wire logic ser_in,
   input wire logic ir_in,
   input wire logic [3:0] char_bits,
   // Event
   output logic break_pulse
);
   brk_state_t state_r, state_nxt;
   logic [3:0] sub_r, sub_nxt;
   logic [3:0] bits_r, bits_nxt;
   logic seen_r, seen_nxt, all_r, all_nxt;
   logic pulse_r, pulse_nxt;
   logic low_now, bit_ok;

   assign break_pulse = pulse_r;

   // =========================================================
   // Low time measured in whole bit periods
   always_comb begin
      state_nxt = state_r;
      sub_nxt = sub_r;
      bits_nxt = bits_r;
      seen_nxt = seen_r;
      all_nxt = all_r;
      pulse_nxt = 1'b0;
      low_now = ir_mode ? !ir_in : !ser_in;
      // IR line pulses low each bit, normal line stays low
      bit_ok = ir_mode ? (seen_r | low_now) : (all_r & low_now); // RULE11 RULE12
      if (baud_tick) begin
         sub_nxt = sub_r + 4'h1;
         seen_nxt = seen_r | low_now;
         all_nxt = all_r & low_now;
         if (sub_r == 4'(`OVERSAMPLE - 1)) begin
            sub_nxt = 4'h0;
            seen_nxt = 1'b0;
            all_nxt = 1'b1;
            unique case (state_r)
               BRK_HUNT: begin
                  if (!bit_ok) begin
                     bits_nxt = 4'h0;
                  end else if (bits_r >= char_bits) begin
                     // One event per break, held until line recovers
                     pulse_nxt = 1'b1; // RULE11 RULE12 RULE13
                     state_nxt = BRK_HOLD;
                  end else begin
                     bits_nxt = bits_r + 4'h1;
                  end
               end
               BRK_HOLD: begin
                  if (!bit_ok) begin
                     state_nxt = BRK_HUNT;
                     bits_nxt = 4'h0;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= BRK_HUNT;
         sub_r <= 4'h0;
         bits_r <= 4'h0;
         seen_r <= 1'b0;
         all_r <= 1'b1;
         pulse_r <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         sub_r <= sub_nxt;
         bits_r <= bits_nxt;
         seen_r <= seen_nxt;
         all_r <= all_nxt;
         pulse_r <= pulse_nxt;
      end
   end

   a_brk_single: assert property ( // RULE13
      @(posedge ref_clk) disable iff (rst)
      (ce && pulse_r) |-> state_r == BRK_HOLD)
      else $error("break event without hold state");
endmodule

/* File: hw/uart_modem_ctrl_line_status.sv */
`timescale 1ns/1ps
`include "uart_mcls_defs.svh"

// Behaviour
// RULE1 - Second aux pin is the inverse of its control bit.
// RULE2 - First aux pin is the inverse of its control bit.
// RULE3 - Loopback holds aux and request-to-send pins high, loops bits inside.
// RULE4 - Without auto flow, request-to-send pin is inverse of its bit.
// RULE5 - Auto flow with fifos forces request-to-send high above rx trigger.
// RULE6 - Fifo mode: rx fifo error flag sets on any errored entry.
// RULE7 - Status read clears that flag only when no errors lie behind head.
// RULE8 - Transmitter empty when shift and fifo or holding empty; resets one.
// RULE9 - Normal mode: holding empty sets as last word leaves; interrupt.
// RULE10 - Programmable mode with fifos: flag means full, threshold interrupts.
// RULE11 - Normal line low beyond a full character time sets break.
// RULE12 - Infrared low pulses beyond a full character time set break.
// RULE13 - A break yields exactly one all-zero character.
// RULE14 - Fifo mode: break shown when its character reaches head.
// RULE15 - Non-fifo mode: break shown at once until status is read.
// RULE16 - Loopback disconnects modem inputs and feeds outputs back.
// RULE17 - Control bit selects infrared or normal break detection.
// RULE18 - Per-character parity, framing and break status kept per entry.
module uart_modem_ctrl_line_status import uart_mcls_pkg::*; #(
   parameter int RX_DEPTH = 16,
   parameter int TX_DEPTH = 16,
   parameter bit AUTO_FLOW = 1'b1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // Register port
   input wire logic [31:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // Character format and serial inputs
   input wire logic [1:0] data_len_sel,
   input wire logic parity_en,
   input wire logic baud_tick,
   input wire logic ser_in,
   input wire logic ir_in,
   // Receive datapath
   input wire logic rx_push,
   input wire logic rx_parity_err,
   input wire logic rx_framing_err,
   input wire logic rx_pop,
   output logic break_char_push,
   // Transmit datapath
   input wire logic tx_shift_empty,
   input wire logic tx_load,
   input wire logic tx_write,
   input wire logic [$clog2(TX_DEPTH):0] tx_count,
   // Modem pins
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ri_n,
   input wire logic dcd_n,
   output logic dtr_n,
   output logic rts_n,
   output logic aux_output_one_pin,
   output logic aux_output_two_pin,
   // Modem inputs as seen inside
   output logic cts_st,
   output logic dsr_st,
   output logic ri_st,
   output logic dcd_st,
   // Interrupt
   output logic irq
);
   localparam int CW = $clog2(RX_DEPTH) + 1;
   localparam int PW = $clog2(RX_DEPTH);
   localparam int TW = $clog2(TX_DEPTH) + 1;

   initial begin
      if (RX_DEPTH < 4 || (RX_DEPTH & (RX_DEPTH - 1)) != 0 ||
          TX_DEPTH < 4 || (TX_DEPTH & (TX_DEPTH - 1)) != 0) begin
         $error("fifo depths must be powers of two, at least 4");
      end
   end

   // =========================================================
   // Register state
   logic [6:0] mc_r, mc_nxt;
   logic [7:0] fc_r, fc_nxt;
   logic ptime_r, ptime_nxt;
   logic [2:0] mask_r, mask_nxt, stat_r, stat_nxt;
   logic rfe_r, rfe_nxt, bi_r, bi_nxt;
   logic thre_r, thre_nxt, temt_r, temt_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic irq_r, irq_nxt;
   logic below_r, below_nxt;
   logic [15:0] ls_val;
   logic ls_rd, is_rd, fifo_en, ptime_act, loop;
   logic thre_evt, below;
   logic [TW-1:0] tx_lvl;

   // =========================================================
   // Receive status fifo state
   rx_stat_t mem_r [RX_DEPTH];
   rx_stat_t mem_nxt [RX_DEPTH];
   rx_stat_t push_stat, head;
   logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt, err_r, err_nxt, rx_trig, behind;
   logic arrive_r, arrive_nxt;
   logic brk_pulse, push, push_ok, pop_ok, push_err, head_err, above;
   logic [3:0] char_bits;

   // =========================================================
   // Pin and output state
   logic dtr_r, rts_r, out1_r, out2_r, bcp_r;
   logic dtr_nxt, rts_nxt, out1_nxt, out2_nxt, bcp_nxt;
   logic cts_r, dsr_r, ri_r, dcd_r;
   logic cts_nxt, dsr_nxt, ri_nxt, dcd_nxt;

   assign reg_rdata = rdata_r;
   assign irq = irq_r;
   assign dtr_n = dtr_r;
   assign rts_n = rts_r;
   assign aux_output_one_pin = out1_r;
   assign aux_output_two_pin = out2_r;
   assign cts_st = cts_r;
   assign dsr_st = dsr_r;
   assign ri_st = ri_r;
   assign dcd_st = dcd_r;
   assign break_char_push = bcp_r;

   // Receiver checks only the first stop bit
   assign char_bits = 4'(`START_STOP_BITS + 5) + {2'b00, data_len_sel}
      + {3'b000, parity_en};

   break_detector brk_i (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .baud_tick(baud_tick),
      .ir_mode(mc_r[`MC_SIRE]), // RULE17
      .ser_in(ser_in),
      .ir_in(ir_in),
      .char_bits(char_bits),
      .break_pulse(brk_pulse)
   );

   // =========================================================
   // Receive status fifo
   always_comb begin
      push = rx_push | brk_pulse;
      // A break character carries framing and parity marks as well
      push_stat.bi = brk_pulse; // RULE18
      push_stat.fe = rx_framing_err | brk_pulse;
      push_stat.pe = rx_parity_err | brk_pulse;
      push_err = |push_stat;
      head = mem_r[rp_r];
      head_err = (cnt_r != '0) && (|head);
      pop_ok = rx_pop && (cnt_r != '0);
      push_ok = push && ((cnt_r != CW'(RX_DEPTH)) || pop_ok);
      wp_nxt = push_ok ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop_ok ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + CW'(push_ok) - CW'(pop_ok);
      err_nxt = err_r + CW'(push_ok && push_err)
         - CW'(pop_ok && head_err);
      arrive_nxt = pop_ok ? ((cnt_r > CW'(1)) || push_ok)
         : (push_ok && (cnt_r == '0));
      behind = err_r - CW'(head_err);
   end

   for (genvar i = 0; i < RX_DEPTH; i++) begin : g_entry
      always_comb begin
         mem_nxt[i] = mem_r[i];
         if (push_ok && (wp_r == PW'(i))) begin
            mem_nxt[i] = push_stat; // RULE18
         end
      end
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            mem_r[i] <= '0;
         end else if (ce) begin
            mem_r[i] <= mem_nxt[i];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         err_r <= '0;
         arrive_r <= 1'b0;
      end else if (ce) begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         err_r <= err_nxt;
         arrive_r <= arrive_nxt;
      end
   end

   // =========================================================
   // Registers, flags and interrupt
   always_comb begin
      mc_nxt = mc_r;
      fc_nxt = fc_r;
      ptime_nxt = ptime_r;
      mask_nxt = mask_r;
      fifo_en = fc_r[`FC_EN];
      ptime_act = ptime_r && fifo_en;
      loop = mc_r[`MC_LOOP];
      ls_rd = reg_rd && (reg_addr == `ADDR_LINE_STATUS);
      is_rd = reg_rd && (reg_addr == `ADDR_IRQ_STATUS);
      if (reg_wr) begin
         unique case (reg_addr)
            `ADDR_MODEM_CONTROL: begin
               mc_nxt = reg_wdata[6:0];
               // Flow enable is writeable only with the option built in
               if (!AUTO_FLOW) begin
                  mc_nxt[`MC_AFCE] = mc_r[`MC_AFCE];
               end
            end
            `ADDR_FIFO_CONTROL: fc_nxt = reg_wdata[7:0];
            `ADDR_INTERRUPT_ENABLE: ptime_nxt = reg_wdata[`IE_PTIME];
            `ADDR_IRQ_MASK: mask_nxt = reg_wdata[2:0];
            default: ;
         endcase
      end
      // Transmit side
      temt_nxt = tx_shift_empty && (tx_count == '0); // RULE8
      unique case (fc_r[`FC_TXT_LO +: 2])
         2'b00: tx_lvl = '0;
         2'b01: tx_lvl = TW'(2);
         2'b10: tx_lvl = TW'(TX_DEPTH / 4);
         default: tx_lvl = TW'(TX_DEPTH / 2);
      endcase
      below = tx_count <= tx_lvl;
      below_nxt = below;
      thre_evt = 1'b0;
      thre_nxt = thre_r;
      if (ptime_act) begin
         thre_nxt = tx_count == TW'(TX_DEPTH); // RULE10
         thre_evt = below && !below_r; // RULE10
      end else if (tx_write) begin
         thre_nxt = 1'b0;
      end else if (tx_load && (tx_count == TW'(1))) begin
         thre_nxt = 1'b1; // RULE9
         thre_evt = 1'b1; // RULE9
      end
      // Receive error flag, set wins over a clearing read
      rfe_nxt = rfe_r;
      if (ls_rd && (behind == '0)) begin
         rfe_nxt = 1'b0; // RULE7
      end
      if (push_ok && push_err) begin
         rfe_nxt = 1'b1; // RULE6
      end
      if (!fifo_en) begin
         rfe_nxt = 1'b0;
      end
      bi_nxt = ls_rd ? 1'b0 : bi_r;
      if (fifo_en ? (arrive_r && head.bi) : brk_pulse) begin
         bi_nxt = 1'b1; // RULE14 RULE15
      end
      // Interrupt status, cleared by its own read
      stat_nxt = is_rd ? `IRQ_RST : stat_r;
      stat_nxt[`IRQ_THRE] = stat_nxt[`IRQ_THRE] | thre_evt;
      stat_nxt[`IRQ_BI] = stat_nxt[`IRQ_BI] | (bi_nxt & !bi_r);
      stat_nxt[`IRQ_RFE] = stat_nxt[`IRQ_RFE] | (rfe_nxt & !rfe_r);
      irq_nxt = |(stat_nxt & mask_nxt);
      ls_val = '0;
      ls_val[`LS_RFE] = rfe_r;
      ls_val[`LS_TEMT] = temt_r;
      ls_val[`LS_THRE] = thre_r;
      ls_val[`LS_BI] = bi_r;
      // Read data stand for one cycle only
      rdata_nxt = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            `ADDR_MODEM_CONTROL: rdata_nxt = {9'h000, mc_r};
            `ADDR_LINE_STATUS: rdata_nxt = ls_val;
            `ADDR_FIFO_CONTROL: rdata_nxt = {8'h00, fc_r};
            `ADDR_INTERRUPT_ENABLE: rdata_nxt = {8'h00, ptime_r, 7'h00};
            `ADDR_IRQ_STATUS: rdata_nxt = {13'h0000, stat_r};
            `ADDR_IRQ_MASK: rdata_nxt = {13'h0000, mask_r};
            default: rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mc_r <= `MC_RST;
         fc_r <= `FC_RST;
         ptime_r <= 1'b0;
         mask_r <= `IRQ_RST;
         stat_r <= `IRQ_RST;
         rfe_r <= 1'b0;
         bi_r <= 1'b0;
         thre_r <= `THRE_RST;
         temt_r <= `TEMT_RST;
         below_r <= 1'b1;
         rdata_r <= '0;
         irq_r <= 1'b0;
      end else if (ce) begin
         mc_r <= mc_nxt;
         fc_r <= fc_nxt;
         ptime_r <= ptime_nxt;
         mask_r <= mask_nxt;
         stat_r <= stat_nxt;
         rfe_r <= rfe_nxt;
         bi_r <= bi_nxt;
         thre_r <= thre_nxt;
         temt_r <= temt_nxt;
         below_r <= below_nxt;
         rdata_r <= rdata_nxt;
         irq_r <= irq_nxt;
      end
   end

   // =========================================================
   // Modem pins and looped inputs
   always_comb begin
      unique case (fc_r[`FC_RXT_LO +: 2])
         2'b00: rx_trig = CW'(1);
         2'b01: rx_trig = CW'(RX_DEPTH / 4);
         2'b10: rx_trig = CW'(RX_DEPTH / 2);
         default: rx_trig = CW'(RX_DEPTH - 2);
      endcase
      above = cnt_r > rx_trig;
      dtr_nxt = loop | !mc_r[`MC_DTR];
      out1_nxt = loop | !mc_r[`MC_OUT1]; // RULE2 RULE3
      out2_nxt = loop | !mc_r[`MC_OUT2]; // RULE1 RULE3
      rts_nxt = !mc_r[`MC_RTS]; // RULE4
      if (AUTO_FLOW && mc_r[`MC_AFCE] && fifo_en && above) begin
         rts_nxt = 1'b1; // RULE5
      end
      rts_nxt = rts_nxt | loop; // RULE3
      // Outputs fed back in loopback, pins ignored
      cts_nxt = loop ? mc_r[`MC_RTS] : !cts_n; // RULE16
      dsr_nxt = loop ? mc_r[`MC_DTR] : !dsr_n; // RULE16
      ri_nxt = loop ? mc_r[`MC_OUT1] : !ri_n; // RULE3
      dcd_nxt = loop ? mc_r[`MC_OUT2] : !dcd_n; // RULE3
      bcp_nxt = brk_pulse; // RULE13
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dtr_r <= 1'b1;
         rts_r <= 1'b1;
         out1_r <= 1'b1;
         out2_r <= 1'b1;
         cts_r <= 1'b0;
         dsr_r <= 1'b0;
         ri_r <= 1'b0;
         dcd_r <= 1'b0;
         bcp_r <= 1'b0;
      end else if (ce) begin
         dtr_r <= dtr_nxt;
         rts_r <= rts_nxt;
         out1_r <= out1_nxt;
         out2_r <= out2_nxt;
         cts_r <= cts_nxt;
         dsr_r <= dsr_nxt;
         ri_r <= ri_nxt;
         dcd_r <= dcd_nxt;
         bcp_r <= bcp_nxt;
      end
   end

   // =========================================================
   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_aux_two_inv: assert property ( // RULE1
      (ce && !loop) |=> out2_r == !$past(mc_r[`MC_OUT2]))
      else $error("aux two pin not inverse of bit");
   a_aux_one_inv: assert property ( // RULE2
      (ce && !loop) |=> out1_r == !$past(mc_r[`MC_OUT1]))
      else $error("aux one pin not inverse of bit");
   a_loop_pins_high: assert property ( // RULE3
      (ce && loop) |=> (rts_r && out1_r && out2_r
      && dcd_r == $past(mc_r[`MC_OUT2])))
      else $error("loopback pins not held high");
   a_rts_manual: assert property ( // RULE4
      (ce && !loop && !mc_r[`MC_AFCE]) |=> rts_r == !$past(mc_r[`MC_RTS]))
      else $error("request to send not inverse of bit");
   a_rts_auto_gate: assert property ( // RULE5
      (ce && AUTO_FLOW && mc_r[`MC_AFCE] && fifo_en && above) |=> rts_r)
      else $error("auto flow did not deassert request to send");
   a_rfe_on_error: assert property ( // RULE6
      (ce && fifo_en && push_ok && push_err) |=> rfe_r)
      else $error("rx fifo error flag not set");
   a_rfe_kept: assert property ( // RULE7
      (ce && ls_rd && rfe_r && fifo_en && behind != '0) |=> rfe_r)
      else $error("rx fifo error flag cleared too early");
   a_temt_follow: assert property ( // RULE8
      ce |=> temt_r == $past(tx_shift_empty && tx_count == '0))
      else $error("transmitter empty flag wrong");
   a_thre_set_irq: assert property ( // RULE9
      (ce && !ptime_act && !tx_write && tx_load && tx_count == TW'(1))
      |=> (thre_r && stat_r[`IRQ_THRE]))
      else $error("holding empty not set on last load");
   a_thre_full: assert property ( // RULE10
      (ce && ptime_act) |=> thre_r == $past(tx_count == TW'(TX_DEPTH)))
      else $error("holding flag not tracking full");
   a_break_one_char: assert property ( // RULE13
      (ce && brk_pulse) |=> bcp_r)
      else $error("break character not pushed");
   a_bi_nonfifo: assert property ( // RULE15
      (ce && !fifo_en && brk_pulse) |=> bi_r)
      else $error("break flag not set at once");
   a_bi_head: assert property ( // RULE14
      (ce && fifo_en && arrive_r && head.bi) |=> bi_r)
      else $error("break flag not shown at head");
   a_loop_inputs: assert property ( // RULE16
      (ce && loop) |=> cts_r == $past(mc_r[`MC_RTS]))
      else $error("loopback input not fed back");

   c_loopback: cover property (ce && loop ##1 ce && !loop);
   c_break_seen: cover property (brk_pulse ##[1:20] bi_r);
   c_rfe_cleared: cover property (rfe_r ##1 !rfe_r);
   c_auto_gate: cover property (mc_r[`MC_AFCE] && fifo_en && above);
endmodule

/* File: sim/modem_model.sv */
`timescale 1ns/1ps
// ==========================================
// Far-side modem, lines asserted, break on command
module modem_model (
   // Clock and control
   input wire logic ref_clk,
   input wire logic baud_tick,
   input wire logic brk_on,
   input wire logic ir_on,
   // Lines toward the block
   output logic ser_in,
   output logic ir_in,
   output logic cts_n,
   output logic dsr_n,
   output logic ri_n,
   output logic dcd_n
);
   logic [3:0] tick_r = 4'h0;
   // Always asserted, so loopback must hide them
   assign {cts_n, dsr_n, ri_n, dcd_n} = 4'h0;
   assign ser_in = !brk_on;
   // One short low pulse per bit period, an infrared zero
   assign ir_in = !(ir_on && tick_r < 4'h3);
   always @(posedge ref_clk) begin
      if (baud_tick) begin
         tick_r <= tick_r + 4'h1;
      end
   end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`include "uart_mcls_defs.svh"
module tb_top import uart_mcls_pkg::*; ;
   logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, baud_tick = 0;
   logic [31:0] reg_addr = 0;
   logic [15:0] reg_wdata = 0;
   logic rx_framing_err = 0;
   logic [1:0] data_len_sel = 0;
   logic parity_en = 0, rx_push = 0, rx_parity_err = 0, rx_pop = 0;
   logic tx_shift_empty = 1, tx_load = 0, tx_write = 0;
   logic [4:0] tx_count = 0;
   logic brk_on = 0, ir_on = 0;
   logic [15:0] reg_rdata;
   logic dtr_n, rts_n, out1, out2, cts_st, dsr_st, ri_st, dcd_st, irq;
   logic ser_in, ir_in, cts_n, dsr_n, ri_n, dcd_n, break_char_push;
   int bad_count = 0, num_checks = 0, brk_n = 0, cyc = 0;
   wire [15:0] pins = {12'h000, dtr_n, rts_n, out1, out2};
   wire [15:0] seen = {12'h000, cts_st, dsr_st, ri_st, dcd_st};

   // ==========================================
   // Clock, tick, break counter, hang guard
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      baud_tick <= ~baud_tick;
      if (break_char_push === 1'b1) brk_n++;
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         stop_test();
      end
   end

   uart_modem_ctrl_line_status uart_modem_ctrl_line_status_inst (
      .ref_clk(ref_clk), .rst(rst), .ce(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .data_len_sel(data_len_sel), .parity_en(parity_en),
      .baud_tick(baud_tick), .ser_in(ser_in), .ir_in(ir_in),
      .rx_push(rx_push), .rx_parity_err(rx_parity_err),
      .rx_framing_err(rx_framing_err), .rx_pop(rx_pop),
      .break_char_push(break_char_push),
      .tx_shift_empty(tx_shift_empty), .tx_load(tx_load),
      .tx_write(tx_write), .tx_count(tx_count),
      .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n),
      .dtr_n(dtr_n), .rts_n(rts_n), .aux_output_one_pin(out1),
      .aux_output_two_pin(out2), .cts_st(cts_st), .dsr_st(dsr_st),
      .ri_st(ri_st), .dcd_st(dcd_st), .irq(irq));

   modem_model modem_model_inst (
      .ref_clk(ref_clk), .baud_tick(baud_tick), .brk_on(brk_on),
      .ir_on(ir_on), .ser_in(ser_in), .ir_in(ir_in), .cts_n(cts_n),
      .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));

   // ==========================================
   // Access tasks
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rc(input logic [31:0] a, input logic [15:0] m,
                     input logic [15:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata & m, e);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic push(input logic [1:0] e);
      @(posedge ref_clk);
      rx_push <= 1'b1;
      rx_parity_err <= e[0];
      rx_framing_err <= e[1];
      @(posedge ref_clk);
      rx_push <= 1'b0;
      rx_parity_err <= 1'b0;
      rx_framing_err <= 1'b0;
      step(2);
   endtask
   task automatic pop();
      @(posedge ref_clk);
      rx_pop <= 1'b1;
      @(posedge ref_clk);
      rx_pop <= 1'b0;
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ==========================================
   // Tests
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      rc(`ADDR_LINE_STATUS, 16'hffff, 16'h0060);
      chk(pins, 16'h000f);
      $display("test reset done");
      wr(`ADDR_MODEM_CONTROL, 16'h000e);
      step(2);
      chk(pins, 16'h0008);
      chk(seen, 16'h000f);
      wr(`ADDR_MODEM_CONTROL, 16'h0000);
      step(2);
      chk(pins, 16'h000f);
      $display("test pins done");
      wr(`ADDR_MODEM_CONTROL, 16'h001d);
      step(2);
      chk(pins, 16'h000f);
      chk(seen, 16'h0007);
      rc(`ADDR_MODEM_CONTROL, 16'hffff, 16'h001d);
      $display("test loopback done");
      wr(`ADDR_FIFO_CONTROL, 16'h0001);
      wr(`ADDR_IRQ_MASK, 16'h0004);
      wr(`ADDR_MODEM_CONTROL, 16'h0022);
      push(2'b00);
      chk({15'h0, rts_n}, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      push(2'b10);
      chk({15'h0, rts_n}, 16'h0001);
      chk({15'h0, irq}, 16'h0001);
      rc(`ADDR_LINE_STATUS, 16'hffff, 16'h00e0);
      rc(`ADDR_LINE_STATUS, 16'hffff, 16'h00e0);
      rc(`ADDR_IRQ_STATUS, 16'h0004, 16'h0004);
      step(2);
      chk({15'h0, irq}, 16'h0000);
      pop();
      rc(`ADDR_LINE_STATUS, 16'hffff, 16'h00e0);
      rc(`ADDR_LINE_STATUS, 16'hffff, 16'h0060);
      pop();
      // Parity error alone must raise the flag too
      push(2'b01);
      rc(`ADDR_LINE_STATUS, 16'hffff, 16'h00e0);
      rc(`ADDR_IRQ_STATUS, 16'h0004, 16'h0004);
      pop();
      $display("test rx fifo done");
      @(posedge ref_clk);
      tx_shift_empty <= 1'b0;
      tx_write <= 1'b1;
      @(posedge ref_clk);
      tx_write <= 1'b0;
      tx_count <= 5'h01;
      rc(`ADDR_LINE_STATUS, 16'h0060, 16'h0000);
      @(posedge ref_clk);
      tx_load <= 1'b1;
      @(posedge ref_clk);
      tx_load <= 1'b0;
      tx_count <= 5'h00;
      rc(`ADDR_LINE_STATUS, 16'h0060, 16'h0020);
      chk({15'h0, irq}, 16'h0000);
      wr(`ADDR_IRQ_MASK, 16'h0001);
      step(2);
      chk({15'h0, irq}, 16'h0001);
      rc(`ADDR_IRQ_STATUS, 16'h0001, 16'h0001);
      tx_shift_empty <= 1'b1;
      rc(`ADDR_LINE_STATUS, 16'h0060, 16'h0060);
      // Programmable empty mode, fifos still on, threshold zero
      wr(`ADDR_INTERRUPT_ENABLE, 16'h0080);
      tx_count <= 5'h10;
      rc(`ADDR_LINE_STATUS, 16'h0060, 16'h0020);
      tx_count <= 5'h00;
      rc(`ADDR_LINE_STATUS, 16'h0020, 16'h0000);
      rc(`ADDR_IRQ_STATUS, 16'h0001, 16'h0001);
      wr(`ADDR_INTERRUPT_ENABLE, 16'h0000);
      $display("test tx done");
      wr(`ADDR_FIFO_CONTROL, 16'h0000);
      wr(`ADDR_MODEM_CONTROL, 16'h0000);
      brk_n = 0;
      brk_on <= 1'b1;
      step(320);
      brk_on <= 1'b0;
      step(40);
      chk(brk_n[15:0], 16'h0001);
      rc(`ADDR_LINE_STATUS, 16'h0010, 16'h0010);
      rc(`ADDR_LINE_STATUS, 16'h0010, 16'h0000);
      $display("test break done");
      // Datapath takes the break character, then fifos back on
      pop();
      wr(`ADDR_FIFO_CONTROL, 16'h0001);
      data_len_sel <= 2'h3;
      parity_en <= 1'b1;
      wr(`ADDR_MODEM_CONTROL, 16'h0040);
      brk_n = 0;
      ir_on <= 1'b1;
      step(480);
      ir_on <= 1'b0;
      step(40);
      chk(brk_n[15:0], 16'h0001);
      rc(`ADDR_LINE_STATUS, 16'h0010, 16'h0010);
      $display("test infrared done");
      stop_test();
   end
endmodule
